// file: hw/hilrc_consts.vh
// Purpose: Constants for the host interrupt, LED and reset control block.
// Assumes: Byte-wide host I/O port, offsets relative to the module base address.
// Notes:   Offsets for LED, select and status registers are local choices.
//
// Overview of operation
// - Hardware reset clears LED and select registers; timeout reload value and timeout counter load ffff.
// - Any write to offset 07h resets glue logic and master controller.
// - Master reset line asserts after bytes 8f, 0f, 8f at offset 05h, or on any write to offset 07h.
// - Master enters its stopped state after its reset completes.
// - LED write updates only LEDs whose select bit is set.
// - LED value one switches the LED on, zero off.
// - LED read returns both LED states in bits 1:0.
// - Interrupts reach the base board as a rising edge.
// - Select bits 2:0 route the interrupt to one of the board lines.
// - Bit 4 enables interrupt while the master request line is low.
// - Bit 5 chooses consistency interrupt instead of starting the timeout counter.
// - Bit 6 enables periodic interrupts from the firmware timer line.
// - Interrupt select register is readable.
// - Pending requests are readable in the interrupt status register.
// - Master request holds until host reads shared RAM at 1ffe.
// - Consistency status clears when host sets or cancels a consistency request.
// - A write to the select register clears the firmware timer interrupt, except in a cycle where an enabled timer edge sets it again.
// - Writes to offsets 08h and 09h load the low and high bytes of the 16-bit timeout reload value.
// - Reading the module status register cancels the host consistency request.
`ifndef HILRC_CONSTS_VH
`define HILRC_CONSTS_VH
`define HILRC_OFS_MRST     8'h05
`define HILRC_OFS_MODRST   8'h07
`define HILRC_OFS_TOR_LO   8'h08
`define HILRC_OFS_TOR_HI   8'h09
`define HILRC_OFS_LED      8'h0A
`define HILRC_OFS_ISEL     8'h0B
`define HILRC_OFS_ISTAT    8'h0C
`define HILRC_OFS_MSTAT    8'h0D
`define HILRC_SEQ_B0       8'h8F
`define HILRC_SEQ_B1       8'h0F
`define HILRC_SEQ_B2       8'h8F
`define HILRC_ACK_ADDR     14'h1FFE
`define HILRC_TOR_RESET    16'hFFFF
`define HILRC_LED_RESET    2'h0
`define HILRC_ISEL_RESET   8'h00
`define HILRC_MRST_PULSE   16
`endif

// file: hw/hilrc_top.v
// Purpose: Host-side glue for module reset, LEDs and interrupt routing.
// Assumes: One access per strobe cycle; inputs synchronous to core_clk.
// Notes:   Reads of undefined bits return zero.
`timescale 1ns/100ps
`include "hilrc_consts.vh"
module hilrc_top #(
	parameter MRST_CYCLES = `HILRC_MRST_PULSE
) (
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire [7:0]  io_addr,
	input  wire        io_wr,
	input  wire        io_rd,
	input  wire [7:0]  io_wdata,
	output reg  [7:0]  io_rdata,
	input  wire        dpram_rd,
	input  wire [13:0] dpram_addr,
	input  wire        master_int_request_n,
	input  wire        fw_timer_line,
	input  wire        cons_req_master,
	input  wire        host_cons_set,
	output reg         host_cons_q,
	output reg         module_reset_q,
	output reg         master_reset_line,
	output reg  [15:0] timeout_reload_q,
	output reg  [15:0] timeout_cnt_q,
	output reg  [1:0]  led_q,
	output reg  [5:0]  irq_q,
	output reg         nmi_q
);
	// ****************************************
	// Register access
	// ****************************************
	reg  [7:0]  isel_q;
	reg  [1:0]  seq_q;
	reg  [7:0]  mrst_cnt_q;
	reg         fw_prev_q;
	reg         fw_pend_q;
	reg         cons_pend_q;
	reg         master_pend_q;
	reg         cnt_run_q;
	wire        wr_hit_isel = io_wr && (io_addr == `HILRC_OFS_ISEL);
	wire        wr_mrst     = io_wr && (io_addr == `HILRC_OFS_MRST);
	wire        rd_mstat    = io_rd && (io_addr == `HILRC_OFS_MSTAT);
	wire        soft_rst    = io_wr && (io_addr == `HILRC_OFS_MODRST);
	wire        any_rst     = !rst_n || soft_rst;
	wire        cons_touch  = host_cons_set || rd_mstat;
	wire        fw_rise     = fw_timer_line && !fw_prev_q;
	wire        combined;
	wire [7:0]  ist_val     = {5'h00, fw_pend_q, cons_pend_q, master_pend_q};
	always @(posedge core_clk) begin
		if (any_rst) begin
			isel_q           <= `HILRC_ISEL_RESET;
			led_q            <= `HILRC_LED_RESET;
			timeout_reload_q <= `HILRC_TOR_RESET;
			timeout_cnt_q    <= `HILRC_TOR_RESET;
			seq_q            <= 2'h0;
			host_cons_q      <= 1'b0;
			fw_prev_q        <= 1'b0;
			fw_pend_q        <= 1'b0;
			cons_pend_q      <= 1'b0;
			master_pend_q    <= 1'b0;
			cnt_run_q        <= 1'b0;
		end else begin
			fw_prev_q <= fw_timer_line;
			if (wr_hit_isel)
				isel_q <= io_wdata;
			if (io_wr && io_addr == `HILRC_OFS_LED) begin
				if (io_wdata[0])
					led_q[0] <= io_wdata[2];
				if (io_wdata[1])
					led_q[1] <= io_wdata[3];
			end
			if (io_wr && io_addr == `HILRC_OFS_TOR_LO)
				timeout_reload_q[7:0] <= io_wdata;
			if (io_wr && io_addr == `HILRC_OFS_TOR_HI)
				timeout_reload_q[15:8] <= io_wdata;
			if (wr_mrst) begin
				case (seq_q)
					2'h0: seq_q <= (io_wdata == `HILRC_SEQ_B0) ? 2'h1 : 2'h0;
					2'h1: seq_q <= (io_wdata == `HILRC_SEQ_B1) ? 2'h2 :
						((io_wdata == `HILRC_SEQ_B0) ? 2'h1 : 2'h0);
					2'h2: seq_q <= (io_wdata == `HILRC_SEQ_B2) ? 2'h3 : 2'h0;
					default: seq_q <= 2'h0;
				endcase
			end else if (seq_q == 2'h3) begin
				seq_q <= 2'h0;
			end
			if (host_cons_set)
				host_cons_q <= 1'b1;
			else if (rd_mstat)
				host_cons_q <= 1'b0;
			// Follows the request line, which the master holds low until the acknowledge
			// read; a latched flag would be set again in the acknowledge cycle itself.
			if (dpram_rd && dpram_addr == `HILRC_ACK_ADDR)
				master_pend_q <= 1'b0;
			else
				master_pend_q <= isel_q[4] && !master_int_request_n;
			if (cons_req_master && isel_q[5])
				cons_pend_q <= 1'b1;
			else if (cons_touch)
				cons_pend_q <= 1'b0;
			if (fw_rise && isel_q[6])
				fw_pend_q <= 1'b1;
			else if (wr_hit_isel)
				fw_pend_q <= 1'b0;
			// Timeout counter reloads and starts only when the interrupt path is off; once started it runs down to zero.
			if (cons_req_master && !isel_q[5] && !cnt_run_q) begin
				cnt_run_q     <= 1'b1;
				timeout_cnt_q <= timeout_reload_q;
			end else if (cnt_run_q) begin
				if (timeout_cnt_q == 16'h0000)
					cnt_run_q <= 1'b0;
				else
					timeout_cnt_q <= timeout_cnt_q - 16'h0001;
			end
		end
	end

	// ****************************************
	// Master reset pulse
	// ****************************************
	// Stretched so the master sees a clean reset; it then comes up stopped.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			mrst_cnt_q        <= 8'h00;
			master_reset_line <= 1'b0;
			module_reset_q    <= 1'b0;
		end else begin
			module_reset_q <= soft_rst;
			if (soft_rst || seq_q == 2'h3) begin
				mrst_cnt_q        <= MRST_CYCLES[7:0];
				master_reset_line <= 1'b1;
			end else if (mrst_cnt_q != 8'h00) begin
				mrst_cnt_q <= mrst_cnt_q - 8'h01;
			end else begin
				master_reset_line <= 1'b0;
			end
		end
	end

	// ****************************************
	// Interrupt routing
	// ****************************************
	assign combined = master_pend_q || cons_pend_q || fw_pend_q;
	always @(posedge core_clk) begin
		if (any_rst) begin
			irq_q <= 6'h00;
			nmi_q <= 1'b0;
		end else begin
			// Level rises with the first pending source, giving a positive edge.
			irq_q[0] <= combined && (isel_q[2:0] == 3'h1);
			irq_q[1] <= combined && (isel_q[2:0] == 3'h2);
			irq_q[2] <= combined && (isel_q[2:0] == 3'h3);
			irq_q[3] <= combined && (isel_q[2:0] == 3'h4);
			irq_q[4] <= combined && (isel_q[2:0] == 3'h5);
			irq_q[5] <= combined && (isel_q[2:0] == 3'h6);
			nmi_q    <= combined && (isel_q[2:0] == 3'h7);
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	always @(posedge core_clk) begin
		if (!rst_n) begin
			io_rdata <= 8'h00;
		end else if (io_rd) begin
			case (io_addr)
				`HILRC_OFS_LED:    io_rdata <= {6'h00, led_q};
				`HILRC_OFS_ISEL:   io_rdata <= {1'b0, isel_q[6:4], 1'b0, isel_q[2:0]};
				`HILRC_OFS_ISTAT:  io_rdata <= ist_val;
				`HILRC_OFS_MSTAT:  io_rdata <= {6'h00, cons_pend_q, host_cons_q};
				`HILRC_OFS_TOR_LO: io_rdata <= timeout_reload_q[7:0];
				`HILRC_OFS_TOR_HI: io_rdata <= timeout_reload_q[15:8];
				default:           io_rdata <= 8'h00;
			endcase
		end
	end
endmodule // hilrc_top

// file: testbench/hilrc_master_model.sv
// Purpose: Master controller side of the interrupt request line.
// Assumes: The request line is pulled up while the master releases it.
// Notes:   Only the acknowledge read releases a raised request.
`timescale 1ns/100ps
module hilrc_master_model (
	input  wire        core_clk,
	input  wire        raise,
	input  wire        dpram_rd,
	input  wire [13:0] dpram_addr,
	output reg         master_int_request_n
);
	initial master_int_request_n = 1'b1;
	always @(posedge core_clk) begin
		if (raise)
			master_int_request_n <= 1'b0;
		else if (dpram_rd && dpram_addr == 14'h1ffe)
			master_int_request_n <= 1'b1;
	end
endmodule // hilrc_master_model

// file: testbench/hilrc_assertions.sv
// Purpose: Port checker for the host glue block.
// Assumes: At most one host access per cycle.
// Notes:   Reset sequence is spaced by idle cycles, as the bench writes it.
`timescale 1ns/100ps
module hilrc_chk #(
	parameter MRST_CYCLES = 16
) (
	input wire        core_clk,
	input wire        rst_n,
	input wire [7:0]  io_addr,
	input wire        io_wr,
	input wire        io_rd,
	input wire [7:0]  io_wdata,
	input wire [7:0]  io_rdata,
	input wire        host_cons_set,
	input wire        host_cons_q,
	input wire        module_reset_q,
	input wire        master_reset_line,
	input wire [15:0] timeout_reload_q,
	input wire [1:0]  led_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_w5(logic [7:0] d);
		io_wr && io_addr == 8'h05 && io_wdata == d;
	endsequence
	wire w_led = io_wr && io_addr == 8'h0a;
	a_reset_vals: assert property (
		$rose(rst_n) |-> timeout_reload_q == 16'hffff && led_q == 2'h0) else $error("bad reset");
	a_modrst_pulse: assert property (
		io_wr && io_addr == 8'h07 |=> module_reset_q) else $error("no module reset");
	a_mrst_seq: assert property (
		s_w5(8'h8f) ##2 s_w5(8'h0f) ##2 s_w5(8'h8f) |-> ##[1:4] master_reset_line)
		else $error("no master reset");
	a_led_set: assert property (
		w_led && io_wdata[0] |=> led_q[0] == $past(io_wdata[2])) else $error("led1 wrong");
	a_led_keep: assert property (
		w_led && !io_wdata[1] |=> $stable(led_q[1])) else $error("led2 changed");
	a_led_read: assert property (
		io_rd && io_addr == 8'h0a |=> io_rdata == {6'h00, $past(led_q)}) else $error("led read");
	a_tor_low: assert property (
		io_wr && io_addr == 8'h08 |=> timeout_reload_q[7:0] == $past(io_wdata)) else $error("tor lo");
	a_tor_high: assert property (
		io_wr && io_addr == 8'h09 |=> timeout_reload_q[15:8] == $past(io_wdata)) else $error("tor hi");
	a_cons_cancel: assert property (
		io_rd && io_addr == 8'h0d && !host_cons_set |=> !host_cons_q) else $error("cons kept");
	cover property (master_reset_line);
	cover property (module_reset_q);
	cover property (led_q == 2'h3);
endmodule // hilrc_chk
bind hilrc_top hilrc_chk #(.MRST_CYCLES(MRST_CYCLES)) u_chk (.core_clk, .rst_n, .io_addr, .io_wr,
	.io_rd, .io_wdata, .io_rdata, .host_cons_set, .host_cons_q, .module_reset_q,
	.master_reset_line, .timeout_reload_q, .led_q);

// file: testbench/testbench.sv
// Purpose: Register level test of the host glue block.
// Assumes: Inputs change at the falling edge.
// Notes:   A short master reset pulse keeps the run brief.
`timescale 1ns/100ps
module testbench;
	logic        core_clk = 0, rst_n = 0, io_wr = 0, io_rd = 0, dpram_rd = 0;
	logic        fw_timer_line = 0, raise = 0, cons_req = 0, hcs = 0;
	logic [7:0]  io_addr = 8'h00, io_wdata = 8'h00;
	logic [13:0] dpram_addr = 14'h0000;
	wire  [7:0]  io_rdata;
	wire  [15:0] timeout_reload_reg, tcnt;
	wire  [1:0]  led_q;
	wire  [5:0]  irq_q;
	wire         nmi_q, mreq_n, hcons, mrst, mline;
	int          miscompares = 0, comparisons = 0, c, i;
	always #4 core_clk = ~core_clk;
	hilrc_top #(.MRST_CYCLES(2)) u_hilrc_top (.core_clk, .rst_n, .io_addr, .io_wr, .io_rd,
		.io_wdata, .io_rdata, .dpram_rd, .dpram_addr, .master_int_request_n(mreq_n),
		.fw_timer_line, .cons_req_master(cons_req), .host_cons_set(hcs), .host_cons_q(hcons),
		.module_reset_q(mrst), .master_reset_line(mline), .timeout_reload_q(timeout_reload_reg),
		.timeout_cnt_q(tcnt), .led_q, .irq_q, .nmi_q);
	hilrc_master_model u_hilrc_master_model (.core_clk, .raise, .dpram_rd, .dpram_addr,
		.master_int_request_n(mreq_n));
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task step(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		step(1);
		io_addr = a;
		io_wdata = d;
		io_wr = w;
		io_rd = !w;
		step(1);
		io_wr = 0;
		io_rd = 0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		acc(0, a, 8'h00);
		chk(io_rdata, exp);
	endtask
	task pulse(input logic ack);
		step(1);
		dpram_addr = 14'h1ffe;
		dpram_rd = ack;
		raise = !ack;
		step(1);
		dpram_rd = 0;
		raise = 0;
	endtask
	task wait_irq(input logic [6:0] exp);
		for (i = 0; i < 8 && {nmi_q, irq_q} !== exp; i++) step(1);
		chk({nmi_q, irq_q}, exp);
		if (i == 8) report_and_stop();
	endtask
	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		step(6);
		rst_n = 1;
		step(1);
		chk(timeout_reload_reg, 16'hffff);
		chk(tcnt, 16'hffff);
		chk(led_q, 2'h0);
		acc(1, 8'h0a, 8'h05);
		acc(1, 8'h0a, 8'h0a);
		rd(8'h0a, 8'h03);
		acc(1, 8'h0a, 8'h01);
		rd(8'h0a, 8'h02);
		$display("test led done");
		// Each channel change happens with nothing pending, as the host must ensure.
		for (c = 1; c < 8; c++) begin
			acc(1, 8'h0b, {5'h02, c[2:0]});
			rd(8'h0b, {5'h02, c[2:0]});
			pulse(0);
			wait_irq(c == 7 ? 7'h40 : 7'h01 << (c - 1));
			pulse(1);
			wait_irq(7'h00);
		end
		acc(1, 8'h0b, 8'h41);
		pulse(0);
		step(4);
		chk({nmi_q, irq_q}, 7'h00);
		pulse(1);
		fw_timer_line = 1;
		wait_irq(7'h01);
		fw_timer_line = 0;
		step(3);
		chk(irq_q, 6'h01);
		acc(1, 8'h0b, 8'h41);
		wait_irq(7'h00);
		$display("test irq done");
		acc(1, 8'h05, 8'h8f);
		acc(1, 8'h05, 8'h0f);
		acc(1, 8'h05, 8'h8f);
		for (i = 0; i < 6 && mline !== 1'b1; i++) step(1);
		chk(mline, 1'b1);
		if (i == 6) report_and_stop();
		// The master is left alone while its reset runs; only gate registers follow.
		acc(1, 8'h08, 8'h34);
		acc(1, 8'h09, 8'h12);
		chk(timeout_reload_reg, 16'h1234);
		acc(1, 8'h0b, 8'h01);
		step(1);
		cons_req = 1;
		step(1);
		cons_req = 0;
		chk(tcnt, 16'h1234);
		step(1);
		chk(tcnt, 16'h1233);
		acc(1, 8'h0b, 8'h21);
		step(1);
		cons_req = 1;
		step(1);
		cons_req = 0;
		wait_irq(7'h01);
		rd(8'h0c, 8'h02);
		step(1);
		hcs = 1;
		step(1);
		hcs = 0;
		wait_irq(7'h00);
		rd(8'h0d, 8'h01);
		rd(8'h0d, 8'h00);
		acc(1, 8'h07, 8'h00);
		chk(mrst, 1'b1);
		chk(mline, 1'b1);
		step(2);
		chk(timeout_reload_reg, 16'hffff);
		chk(tcnt, 16'hffff);
		chk(led_q, 2'h0);
		$display("test reset paths done");
		report_and_stop();
	end
	task report_and_stop;
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
endmodule // testbench
